// ==== rtl/als_pkg.sv ====
/*
  Shared constants and types of the light sensor readout.
  Assumes a single 50 MHz system clock.
*/
package als_pkg;

  // Bus address and command codes
  localparam logic [6:0] SLAVE_ADDR  = 7'h39;
  localparam logic [7:0] CMD_CONT    = 8'h0c;
  localparam logic [7:0] CMD_ONCE    = 8'h04;
  localparam logic [7:0] CMD_START   = 8'h08;
  localparam logic [7:0] CMD_STOP    = 8'h30;
  localparam logic [7:0] CMD_RESET   = 8'h80;
  localparam int         OFF_BIT     = 7;

  // Result word layout
  localparam int          VALID_BIT    = 15;
  localparam int          COUNT_W      = 15;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Integration period limits in milliseconds
  localparam logic [8:0] TINT_MIN_MS = 9'h032;
  localparam logic [8:0] TINT_MAX_MS = 9'h190;
  localparam logic [8:0] TINT_DEF_MS = 9'h064;

  // Timing: one millisecond tick
  localparam int unsigned CLK_HZ      = 50000000;
  localparam int unsigned TICK_MS     = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Operating modes
  typedef enum logic [2:0] {
    M_OFF  = 3'h1,
    M_CONT = 3'h2,
    M_ONCE = 3'h4
  } als_mode_e;

  // Serial slave states
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_AACK = 7'h04,
    S_WR   = 7'h08,
    S_WACK = 7'h10,
    S_RD   = 7'h20,
    S_RACK = 7'h40
  } als_state_e;

endpackage

// ==== rtl/als_counter.sv ====
/*
  Saturating light pulse counter of the integrator.
  Assumes pulse is a one-cycle edge already in the clock domain.
*/
module als_counter (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  input  wire logic                       clear,
  input  wire logic                       count_en,
  input  wire logic                       pulse,
  output logic [als_pkg::COUNT_W-1:0]     count_o
);

  localparam logic [als_pkg::COUNT_W-1:0] CNT_FULL = 15'h7fff;

  logic [als_pkg::COUNT_W-1:0] cnt_q;

  // Count edges, stick at full scale rather than wrap
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 15'h0000;
    end else if (clk_en) begin
      if (clear) begin
        cnt_q <= 15'h0000;
      end else if (count_en && pulse && cnt_q != CNT_FULL) begin
        cnt_q <= cnt_q + 15'h0001;
      end
    end
  end

  assign count_o = cnt_q;

  property p_cnt_frozen;
    @(posedge ref_clk) disable iff (!rst_n)
    (clk_en && !clear && !count_en) |=> $stable(cnt_q);
  endproperty
  // R9: count frozen
  a_cnt_frozen: assert property (p_cnt_frozen) // R9
    else $error("counter moved while disabled");

endmodule // als_counter

// ==== rtl/als_readout.sv ====
/*
  Ambient light sensor readout: two-wire serial slave, command decode,
  mode control, integration timing and the 16-bit result word.
  Assumes scl/sda and the light pulse arrive asynchronously and that
  the resistor setting tint_ms_i is static while in use.
*/
// Function
// R1: After reset the block is shut down and does not integrate.
// R2: Command 0x0c selects continuous mode, refreshing each period.
// R3: A read at address 0x39 returns the high result byte first.
// R4: In continuous mode bit 15 is 0 until the first period ends.
// R5: In continuous mode the result changes only at a period end.
// R6: Command 0x04 selects one-time mode with bus-timed windows.
// R7: In one-time mode command 0x08 starts an integration.
// R8: Start clears the result to zero and is ignored when continuous.
// R9: Command 0x30 ends a one-time integration and freezes the count.
// R10: Stop sets bit 15 and is ignored in continuous mode.
// R11: In one-time mode bit 15 stays 0 until a stop has been taken.
// R12: A one-time result holds until a new start and stop complete; the code clears it to zero at the new start.
// R13: Command 0x8c returns the block to shutdown from any mode.
// R14: Bytes with bit 7 set shut down and are read back as written.
// R15: The continuous period follows the setting, 50 to 400 ms.
// R16: The recommended setting gives a 100 ms period.
// R17: The master spaces start and stop by multiples of 100 ms.
module als_readout #(
  parameter int unsigned TICK_CYCLES = als_pkg::TICK_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        light_pulse_i,
  input  wire logic [8:0]  tint_ms_i,
  output logic             active_o,
  output logic [15:0]      result_o
);

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  logic [1:0]               rst_sync_q;
  logic                     rst_n;
  logic [11:0]              meta_q;
  logic [11:0]              sync_q;
  logic                     scl_p_q, sda_p_q, pulse_p_q;
  logic                     scl_s, sda_s, pulse_s;
  logic [8:0]               tint_s, period_ms;
  logic                     start_cond, stop_cond, scl_rise, scl_fall;
  als_pkg::als_state_e      state_q;
  als_pkg::als_mode_e       mode_q;
  logic [2:0]               bit_cnt_q;
  logic [7:0]               shreg_q, tx_q, tx_next, cmd_q, cmd_byte_q;
  logic                     rd_dir_q, byte_idx_q, more_q, sda_oe_q;
  logic                     cmd_stb_q, run_q;
  logic [15:0]              snap_q, result_q;
  logic [15:0]              tick_cnt_q;
  logic [8:0]               ms_cnt_q;
  logic                     period_end, go_cont, go_once, go_off;
  logic                     activation, start_cmd, stop_cmd;
  logic                     cnt_clear, cnt_en;
  logic [als_pkg::COUNT_W-1:0] count;

  ////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Two stages; tint is static so a bus sync is safe here
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 12'hfff;
      sync_q <= 12'hfff;
    end else if (clk_en) begin
      meta_q <= {tint_ms_i, light_pulse_i, sda_i, scl_i};
      sync_q <= meta_q;
    end
  end

  // Previous samples for edge detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q   <= 1'b1;
      sda_p_q   <= 1'b1;
      pulse_p_q <= 1'b1;
    end else if (clk_en) begin
      scl_p_q   <= scl_s;
      sda_p_q   <= sda_s;
      pulse_p_q <= pulse_s;
    end
  end

  assign scl_s      = sync_q[0];
  assign sda_s      = sync_q[1];
  assign pulse_s    = sync_q[2];
  assign tint_s     = sync_q[11:3];
  assign start_cond = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_cond  = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign scl_rise   = scl_s && !scl_p_q;
  assign scl_fall   = !scl_s && scl_p_q;

  ////////////////////////////////////////////////////////////////////////
  // Serial slave

  // R3: high byte first
  // R14: shutdown byte read back
  always_comb begin
    if (byte_idx_q) begin
      tx_next = snap_q[7:0];
    end else if (mode_q == als_pkg::M_OFF) begin
      tx_next = cmd_q;
    end else begin
      tx_next = snap_q[15:8];
    end
  end

  // Snapshot at address match keeps both bytes of a word coherent
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= als_pkg::S_IDLE;
      bit_cnt_q  <= 3'h0;
      shreg_q    <= 8'h00;
      tx_q       <= 8'h00;
      rd_dir_q   <= 1'b0;
      byte_idx_q <= 1'b0;
      more_q     <= 1'b0;
      sda_oe_q   <= 1'b0;
      snap_q     <= als_pkg::RESULT_RESET;
      cmd_stb_q  <= 1'b0;
      cmd_byte_q <= 8'h00;
    end else if (clk_en) begin
      cmd_stb_q <= 1'b0;
      if (start_cond) begin
        state_q   <= als_pkg::S_ADDR;
        bit_cnt_q <= 3'h0;
        sda_oe_q  <= 1'b0;
      end else if (stop_cond) begin
        state_q  <= als_pkg::S_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (state_q)
          als_pkg::S_IDLE: begin
          end
          // R3: answer only our address
          als_pkg::S_ADDR: if (scl_rise) begin
            shreg_q   <= {shreg_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              if (shreg_q[6:0] == als_pkg::SLAVE_ADDR) begin
                state_q    <= als_pkg::S_AACK;
                rd_dir_q   <= sda_s;
                snap_q     <= result_q;
                byte_idx_q <= 1'b0;
              end else begin
                state_q <= als_pkg::S_IDLE;
              end
            end
          end
          als_pkg::S_AACK: if (scl_fall) begin
            bit_cnt_q <= 3'h0;
            if (!sda_oe_q) begin
              sda_oe_q <= 1'b1;
            end else if (rd_dir_q) begin
              tx_q     <= tx_next;
              sda_oe_q <= !tx_next[7];
              state_q  <= als_pkg::S_RD;
            end else begin
              sda_oe_q <= 1'b0;
              state_q  <= als_pkg::S_WR;
            end
          end
          als_pkg::S_WR: if (scl_rise) begin
            shreg_q   <= {shreg_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              cmd_stb_q  <= 1'b1;
              cmd_byte_q <= {shreg_q[6:0], sda_s};
              state_q    <= als_pkg::S_WACK;
            end
          end
          als_pkg::S_WACK: if (scl_fall) begin
            if (!sda_oe_q) begin
              sda_oe_q <= 1'b1;
            end else begin
              sda_oe_q  <= 1'b0;
              bit_cnt_q <= 3'h0;
              state_q   <= als_pkg::S_WR;
            end
          end
          als_pkg::S_RD: if (scl_fall) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              sda_oe_q   <= 1'b0;   // Release for the master's ack
              more_q     <= 1'b0;
              byte_idx_q <= !byte_idx_q;
              state_q    <= als_pkg::S_RACK;
            end else begin
              tx_q     <= {tx_q[6:0], 1'b0};
              sda_oe_q <= !tx_q[6];
            end
          end
          als_pkg::S_RACK: begin
            if (scl_rise && !more_q) begin
              if (sda_s) begin
                state_q <= als_pkg::S_IDLE;   // Nack ends the read
              end else begin
                more_q <= 1'b1;
              end
            end else if (scl_fall && more_q) begin
              tx_q      <= tx_next;
              sda_oe_q  <= !tx_next[7];
              bit_cnt_q <= 3'h0;
              more_q    <= 1'b0;
              state_q   <= als_pkg::S_RD;
            end
          end
          default: state_q <= als_pkg::S_IDLE;
        endcase
      end
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Command decode and mode control

  // R13: shutdown on bit 7
  assign go_off     = cmd_stb_q && cmd_byte_q[als_pkg::OFF_BIT];
  assign go_cont    = cmd_stb_q && cmd_byte_q == als_pkg::CMD_CONT;
  assign go_once    = cmd_stb_q && cmd_byte_q == als_pkg::CMD_ONCE;
  assign activation = go_cont || go_once;
  // R8: start ignored outside one-time
  assign start_cmd  = cmd_stb_q && cmd_byte_q == als_pkg::CMD_START &&
                      mode_q == als_pkg::M_ONCE;
  // R10: stop ignored outside one-time
  assign stop_cmd   = cmd_stb_q && cmd_byte_q == als_pkg::CMD_STOP &&
                      mode_q == als_pkg::M_ONCE && run_q;

  // R1: shutdown after reset
  // R2: continuous mode select
  // R6: one-time mode select
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= als_pkg::M_OFF;
    end else if (clk_en) begin
      if (go_off) begin
        mode_q <= als_pkg::M_OFF;
      end else if (go_cont) begin
        mode_q <= als_pkg::M_CONT;
      end else if (go_once) begin
        mode_q <= als_pkg::M_ONCE;
      end
    end
  end

  // R14: keep every written byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= als_pkg::CMD_RESET;
    end else if (clk_en && cmd_stb_q) begin
      cmd_q <= cmd_byte_q;
    end
  end

  // R7: window open between start and stop
  // R9: stop closes window
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
    end else if (clk_en) begin
      if (activation || go_off || stop_cmd) begin
        run_q <= 1'b0;
      end else if (start_cmd) begin
        run_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Integration timing and result

  // R15: clamp the period to the supported range
  always_comb begin
    if (tint_s < als_pkg::TINT_MIN_MS) begin
      period_ms = als_pkg::TINT_MIN_MS;
    end else if (tint_s > als_pkg::TINT_MAX_MS) begin
      period_ms = als_pkg::TINT_MAX_MS;
    end else begin
      period_ms = tint_s;
    end
  end

  // R16: one millisecond per setting step
  assign period_end = mode_q == als_pkg::M_CONT && !activation &&
                      tick_cnt_q == TICK_LAST &&
                      ms_cnt_q == period_ms - 9'h001;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 16'h0000;
      ms_cnt_q   <= 9'h000;
    end else if (clk_en) begin
      if (mode_q != als_pkg::M_CONT || activation) begin
        tick_cnt_q <= 16'h0000;
        ms_cnt_q   <= 9'h000;
      end else if (tick_cnt_q == TICK_LAST) begin
        tick_cnt_q <= 16'h0000;
        ms_cnt_q   <= period_end ? 9'h000 : ms_cnt_q + 9'h001;
      end else begin
        tick_cnt_q <= tick_cnt_q + 16'h0001;
      end
    end
  end

  // R1: no counting while shut down
  assign cnt_en    = mode_q == als_pkg::M_CONT ||
                     (mode_q == als_pkg::M_ONCE && run_q);
  assign cnt_clear = activation || start_cmd || period_end;

  als_counter u_counter (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .clear    (cnt_clear),
    .count_en (cnt_en),
    .pulse    (pulse_s && !pulse_p_q),
    .count_o  (count)
  );

  // R4: invalid until first period
  // R5: loads only at period end
  // R8: start zeroes the word
  // R11: invalid until stop
  // R12: held until next start
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= als_pkg::RESULT_RESET;
    end else if (clk_en) begin
      if (activation || start_cmd) begin
        result_q <= als_pkg::RESULT_RESET;
      end else if (period_end || stop_cmd) begin
        result_q <= {1'b1, count};
      end
    end
  end

  assign result_o = result_q;
  assign active_o = mode_q != als_pkg::M_OFF;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_cmd_taken(logic [7:0] code);
    cmd_stb_q && clk_en && cmd_byte_q == code;
  endsequence

  sequence s_rd_begin;
    state_q == als_pkg::S_AACK && rd_dir_q && sda_oe_q && scl_fall &&
    clk_en && !start_cond && !stop_cond;
  endsequence

  property p_off_idle;
    @(posedge ref_clk) disable iff (!rst_n)
    (mode_q == als_pkg::M_OFF && !activation) |=> $stable(count);
  endproperty
  a_off_idle: assert property (p_off_idle) // R1
    else $error("counting while shut down");

  property p_cont_load;
    @(posedge ref_clk) disable iff (!rst_n)
    (period_end && clk_en) |=> result_q == {1'b1, $past(count)};
  endproperty
  a_cont_load: assert property (p_cont_load) // R2
    else $error("period end did not load a valid result");

  property p_rd_msb;
    @(posedge ref_clk) disable iff (!rst_n)
    (s_rd_begin and (mode_q != als_pkg::M_OFF)) |=>
      tx_q == snap_q[15:8] && state_q == als_pkg::S_RD;
  endproperty
  a_rd_msb: assert property (p_rd_msb) // R3
    else $error("read did not start with the high byte");

  property p_act_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    (activation && clk_en) |=> result_q == als_pkg::RESULT_RESET;
  endproperty
  a_act_clear: assert property (p_act_clear) // R4
    else $error("activation left a valid result");

  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    !(activation || start_cmd || period_end || stop_cmd) |=>
      $stable(result_q);
  endproperty
  a_hold: assert property (p_hold) // R5
    else $error("result changed without a conversion");

  property p_once;
    @(posedge ref_clk) disable iff (!rst_n)
    s_cmd_taken(als_pkg::CMD_ONCE) |=>
      mode_q == als_pkg::M_ONCE && !run_q;
  endproperty
  a_once: assert property (p_once) // R6
    else $error("one-time mode not entered");

  property p_start;
    @(posedge ref_clk) disable iff (!rst_n)
    (s_cmd_taken(als_pkg::CMD_START) and mode_q == als_pkg::M_ONCE) |=>
      result_q == als_pkg::RESULT_RESET && run_q;
  endproperty
  a_start: assert property (p_start) // R8
    else $error("start did not clear and run");

  property p_ign_cont;
    @(posedge ref_clk) disable iff (!rst_n)
    (cmd_stb_q && clk_en && mode_q == als_pkg::M_CONT && !period_end &&
     (cmd_byte_q == als_pkg::CMD_START || cmd_byte_q == als_pkg::CMD_STOP))
      |=> $stable(result_q) && mode_q == als_pkg::M_CONT;
  endproperty
  a_ign_cont: assert property (p_ign_cont) // R10
    else $error("start or stop acted in continuous mode");

  property p_stop;
    @(posedge ref_clk) disable iff (!rst_n)
    (stop_cmd && clk_en) |=>
      result_q[als_pkg::VALID_BIT] && !run_q ##1 $stable(result_q);
  endproperty
  a_stop: assert property (p_stop) // R9
    else $error("stop did not freeze a valid count");

  property p_off;
    @(posedge ref_clk) disable iff (!rst_n)
    (go_off && clk_en) |=>
      mode_q == als_pkg::M_OFF && cmd_q == $past(cmd_byte_q);
  endproperty
  a_off: assert property (p_off) // R13
    else $error("shutdown byte not taken");

  property p_period;
    @(posedge ref_clk) disable iff (!rst_n)
    period_end |-> ms_cnt_q >= als_pkg::TINT_MIN_MS - 9'h001 &&
                   ms_cnt_q <= als_pkg::TINT_MAX_MS - 9'h001;
  endproperty
  a_period: assert property (p_period) // R15
    else $error("period outside 50 to 400 ms");

  property p_def_period;
    @(posedge ref_clk) disable iff (!rst_n)
    (period_end && tint_s == als_pkg::TINT_DEF_MS) |->
      ms_cnt_q == als_pkg::TINT_DEF_MS - 9'h001;
  endproperty
  a_def_period: assert property (p_def_period) // R16
    else $error("recommended setting not 100 ms");

endmodule // als_readout

// ==== testbench/als_bus_master.sv ====
/*
  Two-wire bus master model facing the light sensor readout.
  Assumes a pulled-up data wire fed back on sda_i and a 50 MHz clock.
*/
module als_bus_master (
  input  wire logic ref_clk,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Six clocks a phase, above the slave's minimum
  localparam int HALF = 6;

  // Idle bus: clock driven high, data line released to the pull-up
  initial begin
    scl_o = 1'b1;
    oe_o  = 1'b0;
  end

  task automatic wt();
    repeat (HALF) @(negedge ref_clk);
  endtask

  // One bit: data set while clock low, sampled late in high phase
  task automatic bit_io(input logic b, output logic s);
    oe_o = ~b;
    wt();
    scl_o = 1'b1;
    wt();
    s = sda_i;
    scl_o = 1'b0;
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] b, input logic ack_out,
                         output logic [7:0] r, output logic ack_in);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(ack_out, ack_in);
  endtask

  task automatic start_c();
    oe_o = 1'b1;
    wt();
    scl_o = 1'b0;
  endtask

  task automatic stop_c();
    oe_o = 1'b1;
    wt();
    scl_o = 1'b1;
    wt();
    oe_o = 1'b0;
    wt();
  endtask

  task automatic send_cmd(input logic [6:0] a, input logic [7:0] c,
                          output logic nak);
    logic [7:0] r;
    logic       n2;
    n2 = 1'b0;
    start_c();
    byte_io({a, 1'b0}, 1'b1, r, nak);
    if (!nak) byte_io(c, 1'b1, r, n2);
    stop_c();
    nak = nak | n2;
  endtask

  // high byte first, NACK on the last
  task automatic read(input logic [6:0] a, input int n,
                      output logic [15:0] w, output logic nak);
    logic [7:0] hi, lo;
    logic       k;
    hi = 8'h00;
    lo = 8'h00;
    start_c();
    byte_io({a, 1'b1}, 1'b1, hi, nak);
    if (!nak) byte_io(8'hff, n == 1, hi, k);
    if (!nak && n == 2) byte_io(8'hff, 1'b1, lo, k);
    stop_c();
    w = (n == 2) ? {hi, lo} : {8'h00, hi};
  endtask
endmodule // als_bus_master

// ==== testbench/test_als_readout.sv ====
/*
  Self-checking bench of the light sensor readout.
  Assumes the bus master model and a shortened millisecond tick.
*/
module test_als_readout;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TICK     = 10;
  localparam int LPER     = 8;    // Light source period in clocks
  localparam int CMD_SPAN = 240;  // Master clocks around a command gap
  localparam int FREEZE   = 200;  // Clocks held with clock enable low

  logic        ref_clk, resetn, light, scl, host_oe, en;
  logic        sda_o, sda_oe, active_o, act_prev;
  logic [8:0]  tint;
  logic [15:0] result_o;
  logic [2:0]  lc;
  wire         sda_line;
  int          errors, checked, act_cyc;

  // Open-drain wire with pull-up
  assign sda_line = ~(sda_oe | host_oe);

  als_readout #(.TICK_CYCLES(TICK)) u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(en), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .light_pulse_i(light), .tint_ms_i(tint), .active_o(active_o),
    .result_o(result_o));

  als_bus_master u_host (
    .ref_clk(ref_clk), .sda_i(sda_line), .scl_o(scl), .oe_o(host_oe));

  ////////////////////////////////////////////////////////////////////////
  // Clock, light source and activation timer
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  initial lc = 3'h0;
  always @(negedge ref_clk) lc <= lc + 3'h1;
  assign light = lc[2];

  // Cycles since active_o last rose
  always @(posedge ref_clk) begin
    act_cyc  <= (active_o && !act_prev) ? 0 : act_cyc + 1;
    act_prev <= active_o;
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic close_out();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic cmd(input logic [7:0] c);
    logic nak;
    u_host.send_cmd(als_pkg::SLAVE_ADDR, c, nak);
    chk_b(nak, 1'b0);
  endtask

  task automatic rd(input int n, output logic [15:0] w);
    logic nak;
    u_host.read(als_pkg::SLAVE_ADDR, n, w, nak);
    chk_b(nak, 1'b0);
  endtask

  // Bounded wait for the valid bit
  task automatic wait_valid();
    int n;
    n = 0;
    while (result_o[15] !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 5000) begin
        errors++;
        close_out();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    logic        nak;
    logic [15:0] w;
    chk_w(result_o, 16'h0000);
    chk_b(active_o, 1'b0);
    chk_b(sda_o, 1'b0);
    chk_b(sda_oe, 1'b0);
    rd(1, w);
    chk_w(w, {8'h00, als_pkg::CMD_RESET});
    cyc(600);
    chk_w(result_o, 16'h0000);
    u_host.send_cmd(7'h29, als_pkg::CMD_CONT, nak);
    chk_b(nak, 1'b1);
    chk_b(active_o, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_echo();
    logic [7:0]  v[3] = '{8'ha5, 8'hff, 8'h8c};
    logic [15:0] w;
    foreach (v[i]) begin
      cmd(v[i]);
      chk_b(active_o, 1'b0);
      rd(1, w);
      chk_w(w, {8'h00, v[i]});
    end
    $display("test echo done");
  endtask

  task automatic t_cont();
    logic [8:0]  set[4] = '{9'h01e, 9'h064, 9'h0c8, 9'h1f4};
    int          ms[4] = '{50, 100, 200, 400};
    logic [15:0] w1, w2;
    int          fr, nom;
    foreach (set[i]) begin
      tint = set[i];
      fr = (i == 0) ? FREEZE : 0;
      cmd(als_pkg::CMD_CONT);
      chk_b(active_o, 1'b1);
      chk_b(result_o[15], 1'b0);
      // Clock enable low stalls the period by exactly its length
      if (i == 0) begin
        en = 1'b0;
        cyc(FREEZE);
        en = 1'b1;
      end
      wait_valid();
      chk_b(act_cyc >= ms[i] * TICK + fr - 3 &&
            act_cyc <= ms[i] * TICK + fr + 3, 1'b1);
      nom = ms[i] * TICK / LPER;
      chk_b(result_o[14:0] >= nom - 2 &&
            result_o[14:0] <= nom + 2, 1'b1);
      if (i == 3) begin
        rd(2, w1);
        rd(2, w2);
        chk_w(w2, w1);
        chk_w(w1, result_o);
        cmd(als_pkg::CMD_START);
        chk_w(result_o, w1);
        cmd(als_pkg::CMD_STOP);
        chk_w(result_o, w1);
        chk_b(active_o, 1'b1);
      end
      cmd(8'h8c);
      chk_b(active_o, 1'b0);
    end
    $display("test continuous done");
  endtask

  task automatic t_once();
    logic [15:0] w, held;
    tint = 9'h064;
    cmd(als_pkg::CMD_ONCE);
    chk_b(active_o, 1'b1);
    chk_w(result_o, 16'h0000);
    cyc(600);
    chk_w(result_o, 16'h0000);
    cmd(als_pkg::CMD_STOP);
    chk_w(result_o, 16'h0000);
    cmd(als_pkg::CMD_START);
    chk_w(result_o, 16'h0000);
    // strobe to strobe one 100 ms unit
    cyc(100 * TICK - CMD_SPAN);
    chk_b(result_o[15], 1'b0);
    cmd(als_pkg::CMD_STOP);
    chk_b(result_o[15], 1'b1);
    chk_b(result_o[14:0] >= 100 * TICK / LPER - 2 &&
          result_o[14:0] <= 100 * TICK / LPER + 2, 1'b1);
    held = result_o;
    cyc(600);
    rd(2, w);
    chk_w(w, held);
    rd(2, w);
    chk_w(w, held);
    cmd(als_pkg::CMD_START);
    chk_w(result_o, 16'h0000);
    cmd(8'h8c);
    chk_b(active_o, 1'b0);
    $display("test one-time done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    errors  = 0;
    checked = 0;
    resetn  = 1'b0;
    en      = 1'b1;
    tint    = 9'h064;
    act_prev = 1'b0;
    act_cyc  = 0;
    cyc(12);
    resetn = 1'b1;
    cyc(10);
    t_reset();
    t_echo();
    t_cont();
    t_once();
    close_out();
  end
endmodule // test_als_readout
